//--- wdu_pkg.sv
// Purpose: shared constants, types and register map of the watchdog unit
// Assumes: one 50 MHz clock, plain register port with 32-bit data
// Notes: all offsets are byte addresses of aligned words

package wdu_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	// width of the reset pulse driven to the system (least time)
	localparam int RESET_PULSE_NS = 1000;
	localparam int PULSE_W = 6;
	localparam logic [PULSE_W-1:0] RESET_PULSE_CYC =
		PULSE_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	localparam int PRE_W = 14;
	localparam int DIV_FAST = 256;
	localparam int DIV_SLOW = 16384;
	localparam logic [PRE_W-1:0] DIV_FAST_LAST = PRE_W'(DIV_FAST - 1);
	localparam logic [PRE_W-1:0] DIV_SLOW_LAST = PRE_W'(DIV_SLOW - 1);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] TIMEOUT_RELOAD = 16'hfffc;
	localparam logic [CNT_W-1:0] PREWARN_RELOAD = 16'hfff0;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_STATE = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

	// control word 0 fields
	localparam int C0_INIT = 0;
	localparam int C0_LOCK = 1;
	localparam int C0_KEY_LO = 2;
	localparam int C0_KEY_HI = 7;
	localparam int C0_UPW_LO = 8;
	localparam int C0_UPW_HI = 15;
	localparam int C0_REL_LO = 16;
	localparam int C0_REL_HI = 31;
	// control word 1 fields (bits 7:1 carry the guard like word 0)
	localparam int C1_SLOW = 8;
	localparam int C1_OFF = 9;

	// fixed keys of the two-write access
	localparam logic [5:0] FIXED_PASSWORD = 6'h3c;
	localparam logic [5:0] FIXED_GUARD = 6'h0f;

	// reset values
	localparam logic [CNT_W-1:0] RST_RELOAD = 16'h0000;
	localparam logic [7:0] RST_USER_PW = 8'h00;
	localparam logic RST_INIT_DONE = 1'b0;
	localparam logic RST_SLOW = 1'b0;
	localparam logic RST_OFF = 1'b0;

	// interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_ACCESS = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_PREWARN = 2;
	localparam int IRQ_SERVICE = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_OPEN = 2'b01,
		ST_PREWARN = 2'b10,
		ST_RESET = 2'b11
	} wdu_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} wdu_bus_s;

endpackage

//--- wdu_prescaler.sv
// Purpose: divides the system clock into counter ticks
// Assumes: select and restart are synchronous to core_clk
// Notes: tick is a one-cycle pulse once per selected division

`timescale 1ns/1ps

module wdu_prescaler import wdu_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// control
	input wire logic slow,
	input wire logic restart,
	// tick out
	output logic tick
);

	logic [PRE_W-1:0] div_cnt;
	wire [PRE_W-1:0] limit = slow ? DIV_SLOW_LAST : DIV_FAST_LAST;
	// >= so a switch to the fast rate mid-count still wraps at once
	wire wrap = div_cnt >= limit;
	wire [PRE_W-1:0] next_div_cnt = (restart || wrap) ? '0 : div_cnt + 1'b1;
	wire next_tick = wrap && !restart;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick <= next_tick;
		end
	end

endmodule

//--- wdu_irq.sv
// Purpose: sticky event status, mask and one level interrupt
// Assumes: status bits clear by writing one
// Notes: a set in the same cycle as its clear wins

`timescale 1ns/1ps

module wdu_irq import wdu_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// events
	input wire logic [IRQ_W-1:0] set,
	// software access
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [IRQ_W-1:0] wdata,
	// state
	output logic [IRQ_W-1:0] stat,
	output logic [IRQ_W-1:0] mask,
	output logic irq
);

	wire [IRQ_W-1:0] clr = clr_wr ? wdata : '0;
	wire [IRQ_W-1:0] next_stat = set | (stat & ~clr);
	wire [IRQ_W-1:0] next_mask = mask_wr ? wdata : mask;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stat <= '0;
			mask <= '0;
			irq <= 1'b0;
		end else begin
			stat <= next_stat;
			mask <= next_mask;
			irq <= |(next_stat & next_mask);
		end
	end

endmodule

//--- wdu_watchdog_unit.sv
// Purpose: prewarning watchdog with two-write guarded access and init lock
// Assumes: rst_b is the system reset, por_b the power-on reset
// Notes: sys_rst_req and the double-reset memory survive rst_b
//
// How it works
// - unserviced interval expiry starts reset sequence
// - init lock bit drives write-protect line
// - lock bit changes only through guarded access
// - error raises nmi first, reset later
// - 16-bit up counter, divided clock, reloads
// - two writes, gap between them limited
// - bad password or guard starts reset
// - counter overflow starts reset
// - disable stops timeout, not access checks
// - second reset without service holds reset

`timescale 1ns/1ps

module wdu_watchdog_unit import wdu_pkg::*; (
	// clock and resets
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic por_b,
	// register port
	input wire wdu_bus_s bus_req,
	output logic [31:0] rd_data,
	// system outputs
	output logic init_done_lock_bit,
	output logic nmi,
	output logic sys_rst_req,
	output logic irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	wdu_state_e state;
	wdu_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] reload_val;
	logic [7:0] user_pw;
	logic slow;
	logic off;
	logic reset_seen;
	logic rst_hold;
	logic [PULSE_W-1:0] pulse_cnt;
	logic tick;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	function automatic logic guard_ok(input logic [31:0] d, input logic lock, input logic [5:0] key);
		guard_ok = (d[C0_LOCK] == lock) && (d[C0_KEY_HI:C0_KEY_LO] == key);
	endfunction

	wire [31:0] wd = bus_req.wdata;
	wire wr_c0 = bus_req.wr && (bus_req.addr == OFS_CTRL0);
	wire wr_c1 = bus_req.wr && (bus_req.addr == OFS_CTRL1);
	wire wr_stat = bus_req.wr && (bus_req.addr == OFS_IRQ_STAT);
	wire wr_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);
	wire acc_wr = wr_c0 || wr_c1;
	wire in_normal = state == ST_NORMAL;
	wire in_open = state == ST_OPEN;
	wire in_prewarn = state == ST_PREWARN;

	// first write: fixed key plus user password, lock bit set
	wire pw_hit = in_normal && wr_c0 && guard_ok(wd, 1'b1, FIXED_PASSWORD) &&
		(wd[C0_UPW_HI:C0_UPW_LO] == user_pw);
	// second write: guard key with lock bit clear
	wire good_modify = in_open && acc_wr && guard_ok(wd, 1'b0, FIXED_GUARD);
	// checks stay live while the timeout is off
	wire access_err = ((in_normal && acc_wr && !pw_hit) ||
		(in_open && acc_wr && !good_modify));

	// ------------------------------------------------------------
	// counter events
	// ------------------------------------------------------------
	wire ovf = tick && (cnt == CNT_MAX);
	// open window overflow is the too-long gap between the two writes
	wire ovf_err = ovf && ((in_normal && !off) || in_open);
	wire error_evt = access_err || ovf_err;
	wire rst_fire = in_prewarn && ovf;
	wire pre_restart = error_evt || pw_hit || good_modify;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_NORMAL: begin
				if (error_evt) begin
					next_state = ST_PREWARN;
				end else if (pw_hit) begin
					next_state = ST_OPEN;
				end
			end
			ST_OPEN: begin
				if (error_evt) begin
					next_state = ST_PREWARN;
				end else if (good_modify) begin
					next_state = ST_NORMAL;
				end
			end
			ST_PREWARN: begin
				if (rst_fire) begin
					next_state = ST_RESET;
				end
			end
			// left only by the system reset that we request
			ST_RESET: begin
				next_state = ST_RESET;
			end
		endcase
	end

	// ------------------------------------------------------------
	// counter reload
	// ------------------------------------------------------------
	wire [CNT_W-1:0] new_reload = wr_c0 ? wd[C0_REL_HI:C0_REL_LO] : reload_val;
	wire [CNT_W-1:0] wrap_val = in_open ? TIMEOUT_RELOAD : reload_val;
	wire [CNT_W-1:0] step_val = ovf ? wrap_val : cnt + 1'b1;
	wire [CNT_W-1:0] next_cnt =
		error_evt ? PREWARN_RELOAD :
		pw_hit ? TIMEOUT_RELOAD :
		good_modify ? new_reload :
		(tick && (state != ST_RESET)) ? step_val : cnt;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	wire c0_modify = good_modify && wr_c0;
	wire c1_modify = good_modify && wr_c1;
	// only the guarded second write may move the reload value
	wire [CNT_W-1:0] next_reload = c0_modify ? new_reload : reload_val;
	wire next_lock = c0_modify ? wd[C0_INIT] : init_done_lock_bit;
	wire [7:0] next_user_pw = c0_modify ? wd[C0_UPW_HI:C0_UPW_LO] : user_pw;
	wire next_slow = c1_modify ? wd[C1_SLOW] : slow;
	wire next_off = c1_modify ? wd[C1_OFF] : off;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= ST_NORMAL;
			cnt <= RST_RELOAD;
			reload_val <= RST_RELOAD;
			user_pw <= RST_USER_PW;
			init_done_lock_bit <= RST_INIT_DONE;
			slow <= RST_SLOW;
			off <= RST_OFF;
			nmi <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			reload_val <= next_reload;
			user_pw <= next_user_pw;
			init_done_lock_bit <= next_lock;
			slow <= next_slow;
			off <= next_off;
			nmi <= next_state == ST_PREWARN;
		end
	end

	// ------------------------------------------------------------
	// system reset and double-reset memory
	// ------------------------------------------------------------
	// a proper service clears the memory; a new fire in that cycle wins
	wire next_seen = rst_fire || (reset_seen && !(good_modify && rst_b));
	wire next_hold = rst_hold || (rst_fire && reset_seen);
	wire [PULSE_W-1:0] next_pulse = rst_fire ? RESET_PULSE_CYC :
		(pulse_cnt != '0) ? pulse_cnt - 1'b1 : '0;
	wire next_rst_req = next_hold || (next_pulse != '0);

	always_ff @(posedge core_clk) begin
		if (!por_b) begin
			reset_seen <= 1'b0;
			rst_hold <= 1'b0;
			pulse_cnt <= '0;
			sys_rst_req <= 1'b0;
		end else begin
			reset_seen <= next_seen;
			rst_hold <= next_hold;
			pulse_cnt <= next_pulse;
			sys_rst_req <= next_rst_req;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	wire [31:0] rd_c0 = {reload_val, user_pw, 6'h00, !in_open, init_done_lock_bit};
	wire [31:0] rd_c1 = {22'h000000, off, slow, 8'h00};
	wire [31:0] rd_st = {14'h0000, state, cnt};
	wire [31:0] rd_mux =
		(bus_req.addr == OFS_CTRL0) ? rd_c0 :
		(bus_req.addr == OFS_CTRL1) ? rd_c1 :
		(bus_req.addr == OFS_STATE) ? rd_st :
		(bus_req.addr == OFS_IRQ_STAT) ? {28'h0000000, irq_stat} :
		(bus_req.addr == OFS_IRQ_MASK) ? {28'h0000000, irq_mask} : 32'h00000000;
	wire [31:0] next_rd_data = bus_req.rd ? rd_mux : 32'h00000000;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_data <= 32'h00000000;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------
	wire [IRQ_W-1:0] irq_set = {good_modify, error_evt, ovf_err, access_err};

	wdu_prescaler u_pre (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.slow(slow),
		.restart(pre_restart),
		.tick(tick)
	);

	wdu_irq u_irq (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.set(irq_set),
		.clr_wr(wr_stat),
		.mask_wr(wr_mask),
		.wdata(wd[IRQ_W-1:0]),
		.stat(irq_stat),
		.mask(irq_mask),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_error_seen;
		(in_normal || in_open) && error_evt;
	endsequence

	sequence s_prewarn_run;
		nmi && !sys_rst_req;
	endsequence

	a_nmi_before_reset: assert property (
		s_error_seen |=> s_prewarn_run [*2]
	) else $error("error did not raise nmi ahead of reset");

	a_reset_from_prewarn: assert property (
		$rose(sys_rst_req) |-> $past(in_prewarn) && $past(ovf)
	) else $error("system reset not preceded by prewarning overflow");

	a_overflow_error: assert property (
		in_normal && !off && tick && cnt == CNT_MAX && !acc_wr |=> state == ST_PREWARN && cnt == PREWARN_RELOAD
	) else $error("overflow did not enter prewarning");

	a_off_no_timeout: assert property (
		in_normal && off && ovf && !acc_wr |=> state == ST_NORMAL && cnt == $past(reload_val)
	) else $error("disabled watchdog still timed out");

	a_bad_password: assert property (
		in_normal && wr_c0 && wd[C0_KEY_HI:C0_KEY_LO] != FIXED_PASSWORD |=> in_prewarn && nmi
	) else $error("wrong password accepted");

	a_gap_limit: assert property (
		pw_hit && !ovf_err |=> in_open && cnt == TIMEOUT_RELOAD
	) else $error("open window not started with fixed reload");

	a_open_timeout: assert property (
		in_open && ovf && !acc_wr |=> in_prewarn
	) else $error("too-long gap between writes not caught");

	a_lock_guarded: assert property (
		!$past(c0_modify) && $past(rst_b) |-> $stable(init_done_lock_bit)
	) else $error("init lock changed without guarded access");

	a_service_reload: assert property (
		good_modify && wr_c0 && !ovf_err |=> cnt == $past(wd[C0_REL_HI:C0_REL_LO]) && state == ST_NORMAL && !nmi
	) else $error("service did not reload counter");

	a_double_hold: assert property (@(posedge core_clk) disable iff (!por_b)
		rst_fire && reset_seen |=> (rst_hold && sys_rst_req) [*8]
	) else $error("double reset not held");

endmodule

//--- wdu_core_model.sv
// Purpose: processor core model that services the watchdog unit
// Assumes: plain register port, one-cycle strobes
// Notes: tasks are called from the bench; released lines show inverted values

`timescale 1ns/1ps

module wdu_core_model import wdu_pkg::*; (
	// clock
	input wire logic core_clk,
	// register port
	input wire logic [31:0] rd_data,
	output wdu_bus_s bus_req
);
	initial begin
		bus_req = '0;
	end

	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffffffff};
		#1 q = rd_data;
	endtask

	// first write of a service; second write must follow in time
	task automatic open_key(input logic [7:0] pw);
		wr(OFS_CTRL0, {16'h0000, pw, FIXED_PASSWORD, 2'b10});
	endtask
endmodule

//--- tb_top.sv
// Purpose: self-checking bench of the watchdog unit
// Assumes: core model drives the register port
// Notes: faults end in reset, so each case restarts from reset

`timescale 1ns/1ps

module tb_top import wdu_pkg::*;;
	logic core_clk;
	logic rst_b;
	logic por_b;
	wdu_bus_s bus_req;
	logic [31:0] rd_data;
	logic init_done_lock_bit;
	logic nmi;
	logic sys_rst_req;
	logic irq;
	int miscompares = 0;
	int check_count = 0;

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	wdu_watchdog_unit DUT (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.por_b(por_b),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.init_done_lock_bit(init_done_lock_bit),
		.nmi(nmi),
		.sys_rst_req(sys_rst_req),
		.irq(irq)
	);

	wdu_core_model core (
		.core_clk(core_clk),
		.rd_data(rd_data),
		.bus_req(bus_req)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] v;
		core.rd(a, v);
		chk(nm, e & m, v & m);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	// bounded wait for nmi (0) or the reset request (1)
	task automatic wait_for(input logic sel, input int lim);
		int n;
		n = 0;
		while (((sel ? sys_rst_req : nmi) !== 1'b1) && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("[FAIL] wait expected 1 seen timeout");
			conclude();
		end
	endtask

	// rst_b alone keeps the double-reset memory
	task automatic do_reset(input logic full);
		@(posedge core_clk);
		rst_b <= 1'b0;
		por_b <= ~full;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		int n;
		rst_b = 1'b0;
		por_b = 1'b0;
		do_reset(1'b1);
		rchk("ctrl0", OFS_CTRL0, 32'h2, '1);
		rchk("ctrl1", OFS_CTRL1, 32'h0, '1);
		rchk("state", OFS_STATE, 32'h0, '1);
		rchk("unmapped", 5'h14, 32'h0, '1);
		chk("lock_out", 32'h0, 32'(init_done_lock_bit));
		core.open_key(8'h00);
		rchk("open", OFS_STATE, 32'h0001_0000, 32'h0003_0000);
		core.wr(OFS_CTRL0, {16'hfff0, 8'h5a, FIXED_GUARD, 2'b01});
		chk("lock_out", 32'h1, 32'(init_done_lock_bit));
		rchk("reload", OFS_STATE, 32'h0000_fff0, '1);
		rchk("ctrl0_rd", OFS_CTRL0, 32'hfff0_5a03, '1);
		cyc(3 * 256 + 100);
		rchk("count", OFS_STATE, 32'h0000_fff3, '1);
		rchk("svc_stat", OFS_IRQ_STAT, 32'h8, '1);
		core.wr(OFS_IRQ_MASK, 32'h8);
		cyc(2);
		chk("irq_on", 32'h1, 32'(irq));
		core.wr(OFS_IRQ_STAT, 32'h8);
		cyc(2);
		chk("irq_off", 32'h0, 32'(irq));
		rchk("stat_clr", OFS_IRQ_STAT, 32'h0, '1);
		core.open_key(8'h5a);
		core.wr(OFS_CTRL1, {22'h0, 1'b1, 1'b0, FIXED_GUARD, 2'b00});
		rchk("ctrl1_rd", OFS_CTRL1, 32'h0000_0200, '1);
		rchk("reload_kept", OFS_CTRL0, 32'hfff0_0000, 32'hffff_0000);
		cyc(20 * 256);
		chk("no_nmi_off", 32'h0, 32'(nmi));
		core.wr(OFS_CTRL0, {16'h0000, 8'h00, FIXED_PASSWORD, 2'b10});
		cyc(1);
		chk("nmi_bad_pw", 32'h1, 32'(nmi));
		chk("lock_kept", 32'h1, 32'(init_done_lock_bit));
		chk("rst_later", 32'h0, 32'(sys_rst_req));
		rchk("prewarn", OFS_STATE, 32'h0002_0000, 32'h0003_0000);
		rchk("err_stat", OFS_IRQ_STAT, 32'hd, '1);
		wait_for(1'b1, 18 * 256);
		n = 0;
		while (sys_rst_req === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("pulse_len", 32'(RESET_PULSE_CYC), 32'(n));
		// second fault with no service between
		do_reset(1'b0);
		core.wr(OFS_CTRL0, {16'h0000, 8'h00, 6'h00, 2'b10});
		wait_for(1'b1, 18 * 256);
		cyc(int'(RESET_PULSE_CYC) + 100);
		chk("held", 32'h1, 32'(sys_rst_req));
		do_reset(1'b1);
		cyc(1);
		chk("por_clr", 32'h0, 32'(sys_rst_req));
		core.open_key(8'h00);
		core.wr(OFS_CTRL0, {16'hfff0, 8'h00, FIXED_GUARD, 2'b00});
		cyc(15 * 256);
		chk("no_early", 32'h0, 32'(nmi));
		wait_for(1'b0, 3 * 256);
		rchk("ovf_stat", OFS_IRQ_STAT, 32'he, '1);
		do_reset(1'b1);
		core.open_key(8'h00);
		cyc(3 * 256);
		chk("gap_ok", 32'h0, 32'(nmi));
		wait_for(1'b0, 3 * 256);
		do_reset(1'b1);
		core.open_key(8'h00);
		core.wr(OFS_CTRL1, {22'h0, 1'b0, 1'b1, FIXED_GUARD, 2'b00});
		cyc(600);
		rchk("slow", OFS_STATE, 32'h0, '1);
		core.open_key(8'h00);
		core.wr(OFS_CTRL0, {16'hfff0, 8'h00, 6'h00, 2'b01});
		cyc(1);
		chk("nmi_guard", 32'h1, 32'(nmi));
		chk("lock_guard", 32'h0, 32'(init_done_lock_bit));
		rchk("grd_stat", OFS_IRQ_STAT, 32'hd, '1);
		conclude();
	end
endmodule
